// ---- rtl/tsu_pkg.sv ----
/*
  Package for the time stamp event unit: register map, field positions,
  reset values, event codes, source slots, queue depth and source counts.
  Assumes a 32-bit APB slave with word-aligned byte addresses.
*/
package tsu_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00; // time control register
  localparam logic [7:0] A_STAT  = 8'h04; // raw interrupt status
  localparam logic [7:0] A_INTEN = 8'h08; // interrupt enable register
  localparam logic [7:0] A_PUSH  = 8'h0c; // software push register
  localparam logic [7:0] A_LDVAL = 8'h10; // counter load value
  localparam logic [7:0] A_LDEN  = 8'h14; // counter load enable
  localparam logic [7:0] A_CMPV  = 8'h18; // compare value
  localparam logic [7:0] A_CMPL  = 8'h1c; // compare pulse length
  localparam logic [7:0] A_POP   = 8'h20; // event pop
  localparam logic [7:0] A_EVLO  = 8'h24; // event low word
  localparam logic [7:0] A_EVMID = 8'h28; // event middle word
  localparam logic [7:0] A_EVHI  = 8'h2c; // event high word
  localparam logic [7:0] A_CNT   = 8'h30; // live counter

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int         CTRL_EN_BIT  = 0;
  localparam int         CTRL_POL_BIT = 1;
  localparam int         CTRL_SEL_LSB = 4;
  localparam logic       CTRL_POL_RST = 1'b1; // compare output active high
  localparam logic [4:0] FIFO_DEPTH   = 5'd16;
  localparam int         NSRC         = 16;
  localparam int         NHW          = 8;
  localparam int         NPORT        = 2;

  // ---------------------------------------------------------------
  // event type codes
  // ---------------------------------------------------------------
  localparam logic [3:0] EV_SW   = 4'h0;
  localparam logic [3:0] EV_HW   = 4'h1;
  localparam logic [3:0] EV_ROLL = 4'h2;
  localparam logic [3:0] EV_HALF = 4'h3;
  localparam logic [3:0] EV_RX   = 4'h4;
  localparam logic [3:0] EV_TX   = 4'h5;
  localparam logic [3:0] EV_CMP  = 4'h6;

  // ---------------------------------------------------------------
  // source slots, lowest index wins the queue
  // ---------------------------------------------------------------
  localparam int SRC_SW   = 0;
  localparam int SRC_ROLL = 1;
  localparam int SRC_HALF = 2;
  localparam int SRC_CMP  = 3;
  localparam int SRC_RX   = 4;
  localparam int SRC_TX   = 6;
  localparam int SRC_HW   = 8;

  // record: low=stamp, mid={3'b0,port,type,msg,seq}, high={24'b0,domain}
  function automatic logic [95:0] mk_rec(input logic [3:0] t, input logic [4:0] p,
    input logic [31:0] ts, input logic [3:0] m, input logic [15:0] s, input logic [7:0] d);
    mk_rec = {24'h0, d, 3'h0, p, t, m, s, ts};
  endfunction : mk_rec

endpackage : tsu_pkg

// ---- rtl/ptp_timestamp_event_unit.sv ----
/*
  Time stamp event unit: 32-bit counter, event queue, compare pulse,
  sync pulse and APB register file. I_MCLK is the stamp reference clock.
  Assumes port datapaths drive one-cycle valid pulses on I_MCLK and that
  hardware push inputs are asynchronous slow levels.
*/
// How it works
// - counter held zero while enable clear
// - counter counts up each clock when enabled
// - software may load the counter value
// - event queue holds sixteen records
// - overflow drops silently, no flag
// - pending output and raw status show events
// - pending output gated by enable bit
// - compare pulse lasts programmed length
// - compare edge three clocks after match
// - compare pulse rise queues an event
// - polarity bit sets compare active level
// - sync output follows selected bit, zero disables
// - select code n picks bit 16+n
// - sync waits for fresh rise after select
// - sync lags two clocks, makes no events
// - records are 96 bits, three words
// - stamp valid for push and ethernet events
// - ethernet events carry port, type, seq, domain
// - software push stamps counter at write
// - receive two step via sof stamp, transmit one step at valid
// - two ports each with rx and tx
// - hardware pushes synchronised, rising edge queued
// - wrap to zero queues rollover event
// - crossing midpoint queues half rollover
`timescale 1ns/1ps
`default_nettype none

module ptp_timestamp_event_unit
  import tsu_pkg::*;
(
  input  wire logic        I_MCLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output var  logic [31:0] O_PRDATA,
  output var  logic        O_PREADY,
  output var  logic        O_PSLVERR,
  input  wire logic [1:0]  I_RX_SOF,
  input  wire logic [1:0]  I_RX_VALID,
  input  wire logic [7:0]  I_RX_MSG,
  input  wire logic [31:0] I_RX_SEQ,
  input  wire logic [15:0] I_RX_DOM,
  input  wire logic [1:0]  I_TX_VALID,
  input  wire logic [7:0]  I_TX_MSG,
  input  wire logic [31:0] I_TX_SEQ,
  input  wire logic [15:0] I_TX_DOM,
  input  wire logic [7:0]  I_HW_PUSH,
  output var  logic        O_COMPARE_PULSE_OUT,
  output var  logic        O_SYNC_PULSE_OUT,
  output var  logic        O_TS_PEND
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0]             cnt;
    logic                    en;
    logic                    pol;
    logic [3:0]              sel;
    logic                    pend_en;
    logic [31:0]             ldval;
    logic [31:0]             cmpv;
    logic [15:0]             cmpl;
    logic [1:0]              cmp_dly;
    logic                    cmp_act;
    logic [15:0]             cmp_left;
    logic                    comp_out;
    logic                    sync_arm;
    logic                    sync_s1;
    logic                    sync_out;
    logic [7:0]              hw_m;
    logic [7:0]              hw_s;
    logic [7:0]              hw_d;
    logic [1:0][31:0]        rx_ts;
    logic [15:0]             pv;
    logic [15:0][95:0]       pr;
    logic [15:0][95:0]       mem;
    logic [3:0]              wp;
    logic [3:0]              rp;
    logic [4:0]              num;
    logic                    pready;
    logic [31:0]             prdata;
    logic                    pslverr;
    logic                    pend;
  } st_s;

  st_s                q;
  st_s                n;
  logic               setup;
  logic               wr;
  logic               mapped;
  logic               ld;
  logic               roll;
  logic               half;
  logic               cmp_hit;
  logic               cmp_rise;
  logic               selbit;
  logic               push;
  logic               pop;
  logic [3:0]         pick;
  logic [15:0]        fire;
  logic [15:0][95:0]  rec;
  logic [95:0]        head;
  logic [31:0]        rdmux;

  // ---------------------------------------------------------------
  // bus decode and event sources
  // ---------------------------------------------------------------
  assign setup    = I_PSEL & ~I_PENABLE;
  assign wr       = I_PSEL & I_PENABLE & q.pready & I_PWRITE;
  assign mapped   = (I_PADDR <= A_CNT) && (I_PADDR[1:0] == 2'b00);
  assign ld       = wr && (I_PADDR == A_LDEN) && I_PWDATA[0];
  assign roll     = q.en & ~ld & (q.cnt == 32'hffffffff);
  assign half     = q.en & ~ld & (q.cnt == 32'h7fffffff);
  assign cmp_hit  = q.en & (q.cnt == q.cmpv) & (q.cmpl != 16'h0);
  assign cmp_rise = q.cmp_dly[1];
  assign selbit   = q.cnt[{1'b1, q.sel}];
  assign head     = q.mem[q.rp];
  assign push     = (q.pv != 16'h0) && (q.num < FIFO_DEPTH);
  assign pop      = wr && (I_PADDR == A_POP) && (q.num != 5'd0);

  // fixed sources, stamps invalid for rollovers
  assign fire[SRC_SW]   = wr && (I_PADDR == A_PUSH);
  assign fire[SRC_ROLL] = roll;
  assign fire[SRC_HALF] = half;
  assign fire[SRC_CMP]  = cmp_rise;
  assign rec[SRC_SW]    = mk_rec(EV_SW, 5'd0, q.cnt, 4'h0, 16'h0, 8'h0);
  assign rec[SRC_ROLL]  = mk_rec(EV_ROLL, 5'd0, 32'h0, 4'h0, 16'h0, 8'h0);
  assign rec[SRC_HALF]  = mk_rec(EV_HALF, 5'd0, 32'h0, 4'h0, 16'h0, 8'h0);
  assign rec[SRC_CMP]   = mk_rec(EV_CMP, 5'd0, q.cnt, 4'h0, 16'h0, 8'h0);

  // per-port rx and tx sources; receive stamp taken at sof
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      assign fire[SRC_RX+gp] = I_RX_VALID[gp];
      assign fire[SRC_TX+gp] = I_TX_VALID[gp];
      assign rec[SRC_RX+gp]  = mk_rec(EV_RX, 5'(gp + 1), q.rx_ts[gp], I_RX_MSG[gp*4 +: 4],
                                      I_RX_SEQ[gp*16 +: 16], I_RX_DOM[gp*8 +: 8]);
      assign rec[SRC_TX+gp]  = mk_rec(EV_TX, 5'(gp + 1), q.cnt, I_TX_MSG[gp*4 +: 4],
                                      I_TX_SEQ[gp*16 +: 16], I_TX_DOM[gp*8 +: 8]);
    end
  endgenerate

  // hardware pushes: rising edge after two-flop sync
  genvar gh;
  generate
    for (gh = 0; gh < NHW; gh++) begin : g_hw
      assign fire[SRC_HW+gh] = q.hw_s[gh] & ~q.hw_d[gh];
      assign rec[SRC_HW+gh]  = mk_rec(EV_HW, 5'(gh + 1), q.cnt, 4'h0, 16'h0, 8'h0);
    end
  endgenerate

  // fixed-priority pick among pending sources, lowest slot first
  always_comb begin
    pick = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (q.pv[i]) begin
        pick = 4'(i);
      end
    end
  end

  // read data for the access phase
  always_comb begin
    case (I_PADDR)
      A_CTRL:  rdmux = {24'h0, q.sel, 2'b00, q.pol, q.en};
      A_STAT:  rdmux = {31'h0, q.num != 5'd0};
      A_INTEN: rdmux = {31'h0, q.pend_en};
      A_LDVAL: rdmux = q.ldval;
      A_CMPV:  rdmux = q.cmpv;
      A_CMPL:  rdmux = {16'h0, q.cmpl};
      A_EVLO:  rdmux = head[31:0];
      A_EVMID: rdmux = head[63:32];
      A_EVHI:  rdmux = head[95:64];
      A_CNT:   rdmux = q.cnt;
      default: rdmux = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = q;
    // apb: one-cycle setup then a zero-wait access
    n.pready  = setup;
    n.pslverr = setup & ~mapped;
    n.prdata  = setup ? rdmux : 32'h0;
    if (wr) begin
      case (I_PADDR)
        A_CTRL: begin
          n.en       = I_PWDATA[CTRL_EN_BIT];
          n.pol      = I_PWDATA[CTRL_POL_BIT];
          n.sel      = I_PWDATA[CTRL_SEL_LSB +: 4];
          n.sync_arm = 1'b0;
        end
        A_INTEN: n.pend_en = I_PWDATA[0];
        A_LDVAL: n.ldval   = I_PWDATA;
        A_CMPV:  n.cmpv    = I_PWDATA;
        A_CMPL:  n.cmpl    = I_PWDATA[15:0];
        default: n.en      = q.en;
      endcase
    end
    // counter
    if (!q.en) begin
      n.cnt = 32'h0;
    end else if (ld) begin
      n.cnt = q.ldval;
    end else begin
      n.cnt = q.cnt + 32'h1;
    end
    // compare: two delay flops then the pulse flop
    n.cmp_dly = {q.cmp_dly[0], cmp_hit};
    if (cmp_rise) begin
      n.cmp_act  = (q.cmpl != 16'h0);
      n.cmp_left = q.cmpl;
    end else if (q.cmp_act) begin
      n.cmp_left = q.cmp_left - 16'h1;
      n.cmp_act  = (q.cmp_left != 16'h1);
    end
    n.comp_out = n.pol ? n.cmp_act : ~n.cmp_act;
    // sync: arm on a low bit, so only a fresh rise passes
    if (!wr || I_PADDR != A_CTRL) begin
      if (!selbit) begin
        n.sync_arm = 1'b1;
      end
    end
    n.sync_s1  = (q.sel != 4'h0) & q.sync_arm & selbit;
    n.sync_out = q.sync_s1;
    // hardware push synchronisers
    n.hw_m = I_HW_PUSH;
    n.hw_s = q.hw_m;
    n.hw_d = q.hw_s;
    // receive stamps at start of frame
    for (int p = 0; p < NPORT; p++) begin
      if (I_RX_SOF[p]) begin
        n.rx_ts[p] = q.cnt;
      end
    end
    // pending slots: a new event wins over the drain of its slot
    for (int i = 0; i < NSRC; i++) begin
      if (push && (pick == 4'(i))) begin
        n.pv[i] = 1'b0;
      end
      if (fire[i]) begin
        n.pv[i] = 1'b1;
        n.pr[i] = rec[i];
      end
    end
    // queue, sixteen deep, full simply waits
    if (push) begin
      n.mem[q.wp] = q.pr[pick];
      n.wp        = q.wp + 4'h1;
    end
    if (pop) begin
      n.rp = q.rp + 4'h1;
    end
    n.num  = q.num + {4'h0, push} - {4'h0, pop};
    n.pend = q.pend_en & (n.num != 5'd0);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      q       <= '0;
      q.pol   <= CTRL_POL_RST;
    end else begin
      q <= n;
    end
  end

  assign O_PRDATA  = q.prdata;
  assign O_PREADY  = q.pready;
  assign O_PSLVERR = q.pslverr;
  assign O_COMPARE_PULSE_OUT = q.comp_out;
  assign O_SYNC_PULSE_OUT = q.sync_out;
  assign O_TS_PEND = q.pend;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);

  property p_cnt_zero;
    !q.en |=> q.cnt == 32'h0;
  endproperty
  a_cnt_zero: assert property (p_cnt_zero) else $error("counter not held at zero");

  property p_cnt_inc;
    q.en && !ld |=> q.cnt == $past(q.cnt) + 32'h1;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step");

  property p_load;
    q.en && ld |=> q.cnt == $past(q.ldval);
  endproperty
  a_load: assert property (p_load) else $error("counter load lost");

  // count never passes the depth, and a full queue takes nothing
  property p_depth;
    (q.num <= FIFO_DEPTH) && ((q.num != FIFO_DEPTH) || !push);
  endproperty
  a_depth: assert property (p_depth) else $error("queue depth exceeded");

  property p_pend_off;
    !q.pend_en |=> !q.pend;
  endproperty
  a_pend_off: assert property (p_pend_off) else $error("pending while disabled");

  // more than one record queued keeps pending up even across a pop
  property p_pend_on;
    q.pend_en && (q.num > 5'd1) |=> q.pend;
  endproperty
  a_pend_on: assert property (p_pend_on) else $error("pending dropped while queued");

  // pulse length loaded from the programmed length at the rise
  property p_cmp_len;
    cmp_rise |=> q.cmp_left == $past(q.cmpl);
  endproperty
  a_cmp_len: assert property (p_cmp_len) else $error("compare length not loaded");

  property p_cmp_edge;
    cmp_hit |-> ##3 q.cmp_act;
  endproperty
  a_cmp_edge: assert property (p_cmp_edge) else $error("compare edge late");

  property p_cmp_pol;
    q.comp_out == (q.pol ? q.cmp_act : !q.cmp_act);
  endproperty
  a_cmp_pol: assert property (p_cmp_pol) else $error("compare level wrong");

  property p_cmp_evt;
    cmp_rise |=> q.pv[SRC_CMP] && q.cmp_act;
  endproperty
  a_cmp_evt: assert property (p_cmp_evt) else $error("compare event missing");

  property p_sync_off;
    q.sel == 4'h0 |=> ##1 !q.sync_out;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync active while off");

  property p_sync_dly;
    (q.sel != 4'h0) && q.sync_arm && selbit |-> ##2 q.sync_out;
  endproperty
  a_sync_dly: assert property (p_sync_dly) else $error("sync delay wrong");

  property p_push;
    fire[SRC_SW] |=> q.pv[SRC_SW] && q.pr[SRC_SW][31:0] == $past(q.cnt);
  endproperty
  a_push: assert property (p_push) else $error("push stamp wrong");

  property p_roll;
    roll |=> q.pv[SRC_ROLL] && q.cnt == 32'h0;
  endproperty
  a_roll: assert property (p_roll) else $error("rollover not queued");

  c_cmp:  cover property ($rose(q.cmp_act));
  c_full: cover property (q.num == FIFO_DEPTH);
  c_sync: cover property ($rose(q.sync_out));
  c_hw:   cover property (fire[SRC_HW]);

endmodule : ptp_timestamp_event_unit

`default_nettype wire

// ---- test/port_side_model.sv ----
/*
  Far side of the stamp unit: two switch port datapaths and the
  hardware push sources, driven by tasks that the bench calls.
  Assumes the bench clock is the stamp reference clock.
*/
`timescale 1ns/1ps
`default_nettype none

module port_side_model (
  input  wire logic        i_clk,
  output logic      [1:0]  o_rx_sof,
  output logic      [1:0]  o_rx_valid,
  output logic      [7:0]  o_rx_msg,
  output logic      [31:0] o_rx_seq,
  output logic      [15:0] o_rx_dom,
  output logic      [1:0]  o_tx_valid,
  output logic      [7:0]  o_tx_msg,
  output logic      [31:0] o_tx_seq,
  output logic      [15:0] o_tx_dom,
  output logic      [7:0]  o_hw_push
);
  // ---------------------------------------------------------------
  // packet and push drivers
  // ---------------------------------------------------------------
  // quiet lines at time zero
  initial begin
    {o_rx_sof, o_rx_valid, o_rx_msg, o_rx_seq, o_rx_dom} = '0;
    {o_tx_valid, o_tx_msg, o_tx_seq, o_tx_dom, o_hw_push} = '0;
  end

  // one sync packet: rx marks start of frame first, tx at frame start
  task automatic pkt(input logic tx, input int p, input logic [3:0] m, input logic [15:0] s, input logic [7:0] d);
    if (!tx) begin
      @(posedge i_clk);
      o_rx_sof[p] <= 1'b1;
      @(posedge i_clk);
      o_rx_sof[p] <= 1'b0;
      repeat (4) @(posedge i_clk); // packet parse time
    end
    @(posedge i_clk);
    if (tx) begin
      o_tx_valid[p]       <= 1'b1;
      o_tx_msg[4*p +: 4]  <= m;
      o_tx_seq[16*p +: 16] <= s;
      o_tx_dom[8*p +: 8]  <= d;
    end else begin
      o_rx_valid[p]       <= 1'b1;
      o_rx_msg[4*p +: 4]  <= m;
      o_rx_seq[16*p +: 16] <= s;
      o_rx_dom[8*p +: 8]  <= d;
    end
    @(posedge i_clk);
    // fields invert once unqualified so stale values never match
    o_rx_valid <= 2'b00;
    o_tx_valid <= 2'b00;
    o_rx_msg   <= ~o_rx_msg;
    o_rx_seq   <= ~o_rx_seq;
    o_rx_dom   <= ~o_rx_dom;
    o_tx_msg   <= ~o_tx_msg;
    o_tx_seq   <= ~o_tx_seq;
    o_tx_dom   <= ~o_tx_dom;
  endtask : pkt

  // slow push level, well over ten clocks each way
  task automatic hw_pulse(input int i);
    @(posedge i_clk);
    o_hw_push[i] <= 1'b1;
    repeat (12) @(posedge i_clk);
    o_hw_push[i] <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask : hw_pulse
endmodule : port_side_model

`default_nettype wire

// ---- test/ptp_timestamp_event_unit_tb.sv ----
/*
  Self-checking bench for the stamp event unit: APB master with a
  queue of expected answers, far side model, output checks.
  Assumes the package register map and record layout.
*/
`timescale 1ns/1ps
`default_nettype none

module ptp_timestamp_event_unit_tb;
  import tsu_pkg::*;
  localparam logic [31:0] M_TYPE = 32'h00f0_0000;
  localparam logic [31:0] M_TP   = 32'h1ff0_0000;
  localparam logic [31:0] M_ALL  = 32'hffff_ffff;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, comp, sync, pend;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v, v2;
  logic [1:0]  rx_sof, rx_valid, tx_valid;
  logic [7:0]  rx_msg, tx_msg, hw_push, d;
  logic [31:0] rx_seq, tx_seq;
  logic [15:0] rx_dom, tx_dom, s;
  logic [3:0]  m;
  logic [64:0] expq[$];
  logic [64:0] note;
  int          n_mismatch, checks_done, k;

  // ---------------------------------------------------------------
  // clock, instances, answer monitor
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ptp_timestamp_event_unit u_ptp_timestamp_event_unit (
    .I_MCLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_RX_SOF(rx_sof), .I_RX_VALID(rx_valid), .I_RX_MSG(rx_msg), .I_RX_SEQ(rx_seq), .I_RX_DOM(rx_dom),
    .I_TX_VALID(tx_valid), .I_TX_MSG(tx_msg), .I_TX_SEQ(tx_seq), .I_TX_DOM(tx_dom),
    .I_HW_PUSH(hw_push), .O_COMPARE_PULSE_OUT(comp), .O_SYNC_PULSE_OUT(sync), .O_TS_PEND(pend));

  port_side_model u_port_side_model (
    .i_clk(clk), .o_rx_sof(rx_sof), .o_rx_valid(rx_valid), .o_rx_msg(rx_msg), .o_rx_seq(rx_seq),
    .o_rx_dom(rx_dom), .o_tx_valid(tx_valid), .o_tx_msg(tx_msg), .o_tx_seq(tx_seq), .o_tx_dom(tx_dom),
    .o_hw_push(hw_push));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // oldest note against each completed transfer: {err, mask, data}
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
      note = expq.pop_front();
      chk({31'h0, pslverr}, {31'h0, note[64]});
      chk(prdata & note[63:32], note[31:0]);
    end
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [64:0] n_exp,
                     output logic [31:0] r);
    int n;
    expq.push_back(n_exp);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    apb(1'b1, a, wd, 65'h0, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, {1'b0, M_ALL, e}, r);
  endtask : rd

  task automatic rdv(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, 65'h0, r);
  endtask : rdv

  // read oldest record, check middle and high words, then pop it
  task automatic ev(input logic [31:0] mid, input logic [31:0] mm, input logic [7:0] dom, input logic [31:0] hm,
                    output logic [31:0] stamp);
    logic [31:0] r;
    apb(1'b0, A_EVMID, 32'h0, {1'b0, mm, mid & mm}, r);
    apb(1'b0, A_EVHI, 32'h0, {1'b0, hm, {24'h0, dom} & hm}, r);
    rdv(A_EVLO, stamp);
    wr(A_POP, 32'h1);
  endtask : ev

  function automatic logic [31:0] mid_of(input logic [3:0] t, input logic [4:0] p, input logic [3:0] mt,
                                         input logic [15:0] sq);
    mid_of = {3'h0, p, t, mt, sq};
  endfunction : mid_of

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'h6ecdeb66));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    // reset values and refused places
    rd(A_CTRL, 32'h2);
    rd(A_CNT, 32'h0);
    rd(A_STAT, 32'h0);
    rd(A_INTEN, 32'h0);
    apb(1'b0, 8'h34, 32'h0, {1'b1, M_ALL, 32'h0}, v);
    apb(1'b1, 8'h02, 32'h5, {1'b1, 32'h0, 32'h0}, v);
    // counting: reads three cycles apart
    wr(A_CTRL, 32'h3);
    rdv(A_CNT, v);
    rdv(A_CNT, v2);
    chk(v2 - v, 32'd3);
    // load across midpoint and wrap, then disable
    wr(A_LDVAL, 32'h7fff_fff8);
    wr(A_LDEN, 32'h1);
    repeat (20) @(posedge clk);
    wr(A_LDVAL, 32'hffff_fff8);
    wr(A_LDEN, 32'h1);
    repeat (20) @(posedge clk);
    wr(A_CTRL, 32'h2);
    rd(A_CNT, 32'h0);
    ev(mid_of(EV_HALF, 5'd0, 4'h0, 16'h0), M_TYPE, 8'h0, 32'h0, v);
    chk(v, 32'h0);
    ev(mid_of(EV_ROLL, 5'd0, 4'h0, 16'h0), M_TYPE, 8'h0, 32'h0, v);
    chk(v, 32'h0);
    // software push stamps the write cycle
    wr(A_CTRL, 32'h3);
    rdv(A_CNT, v);
    wr(A_PUSH, 32'h1);
    ev(mid_of(EV_SW, 5'd0, 4'h0, 16'h0), M_TYPE, 8'h0, 32'h0, v2);
    chk({31'h0, (v2 - v) inside {[3:5]}}, 32'h1);
    // ethernet rx and tx on both ports, random fields
    for (int p = 0; p < 2; p++) begin
      for (int t = 0; t < 2; t++) begin
        m = 4'($urandom);
        s = 16'($urandom);
        d = 8'($urandom);
        u_port_side_model.pkt(t[0], p, m, s, d);
        ev(mid_of(t ? EV_TX : EV_RX, 5'(p + 1), m, s), M_ALL, d, M_ALL, v);
      end
    end
    // every hardware push input in turn
    for (int i = 0; i < 8; i++) u_port_side_model.hw_pulse(i);
    for (int i = 0; i < 8; i++) ev(mid_of(EV_HW, 5'(i + 1), 4'h0, 16'h0), M_TP, 8'h0, 32'h0, v);
    // overfill: sixteen queued plus one held in the push slot
    for (int i = 0; i < 20; i++) wr(A_PUSH, 32'h1);
    chk({31'h0, pend}, 32'h0);
    wr(A_INTEN, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, pend}, 32'h1);
    k = 0;
    do begin
      rdv(A_STAT, v);
      if (v[0] === 1'b1) wr(A_POP, 32'h1);
      if (v[0] === 1'b1) k++;
    end while (v[0] === 1'b1 && k < 30);
    chk(k, 32'd17);
    repeat (3) @(posedge clk);
    chk({31'h0, pend}, 32'h0);
    // compare pulse, active high then active low
    for (int pol = 1; pol >= 0; pol--) begin
      wr(A_CTRL, pol ? 32'h3 : 32'h1);
      wr(A_CMPL, 32'h0);
      wr(A_CMPV, 32'h100);
      wr(A_LDVAL, 32'h0e0);
      wr(A_LDEN, 32'h1);
      wr(A_CMPL, 32'h5);
      k = 0;
      repeat (80) begin
        @(posedge clk);
        if (comp === pol[0]) k++;
      end
      chk(k, 32'd5);
      chk({31'h0, comp}, {31'h0, ~pol[0]});
      ev(mid_of(EV_CMP, 5'd0, 4'h0, 16'h0), M_TYPE, 8'h0, 32'h0, v);
    end
    // sync pulse from bit 17, re-armed only by a fresh rise
    wr(A_CTRL, 32'h13);
    wr(A_LDVAL, 32'h0001_ffe0);
    wr(A_LDEN, 32'h1);
    chk({31'h0, sync}, 32'h0);
    repeat (40) @(posedge clk);
    chk({31'h0, sync}, 32'h1);
    wr(A_CTRL, 32'h03);
    repeat (3) @(posedge clk);
    chk({31'h0, sync}, 32'h0);
    wr(A_CTRL, 32'h13);
    repeat (4) @(posedge clk);
    chk({31'h0, sync}, 32'h0);
    rd(A_STAT, 32'h0);
    tally_and_finish();
  end
endmodule : ptp_timestamp_event_unit_tb

`default_nettype wire
